//--- verilog/fcs_pkg.sv
// Summary of operation
// - Sector erase opens with setup byte 20H; one sector is 256 bytes.
// - Erase execute byte follows setup; erase starts on strobe rise, self-timed.
// - Early reset may leave a partial erase; repeating erase is harmless.
// - Program setup 10H; next strobe latches address, then data, then programs.
// - FFH after erase or program setup cancels it and returns to read; the model takes FFH after 10H as data and programs it.
// - After 90H, address 0000H gives maker code, 0001H part code.
// - Seven consecutive reads from 1823H, 1820H, 1822H onward release lock.
// - A different seven-read sequence from 1823H onward re-arms the lock.
// - On a doubtful status read, read twice more; both must be valid.
// - Host runs the unlock sequence before any erase or program.
// - Host should erase a location before programming it.
package fcs_pkg;

  // ****************************************
  // Widths and commands
  // ****************************************
  localparam int ADDR_W = 19;
  localparam int TMO_W = 18;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_EXEC = 8'hD0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR = 19'h00001;
  localparam int SECTOR_LSB = 8;
  localparam int COMPLETION_POLL_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam logic [1:0] CONFIRM_READS = 2'h2;

  // ****************************************
  // Write lock read sequences
  // ****************************************
  localparam int SEQ_LEN = 7;
  localparam logic [2:0] SEQ_LAST = 3'h6;
  localparam logic [15:0] UNLOCK_SEQ [0:SEQ_LEN-1] = '{
    16'h1823, 16'h1820, 16'h1822, 16'h0418, 16'h041B, 16'h0419, 16'h041A};
  localparam logic [15:0] LOCK_SEQ [0:SEQ_LEN-1] = '{
    16'h1823, 16'h1820, 16'h1822, 16'h0418, 16'h0418, 16'h0419, 16'h040A};

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int WE_PULSE_MIN_NS = 15;
  localparam int READ_ACC_NS = 300;
  localparam int ERASE_MAX_MS = 4;
  localparam logic [4:0] WE_PULSE_CYC =
    5'((WE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] READ_ACC_CYC =
    5'((READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SETUP_CYC = 5'h01;
  localparam logic [4:0] HOLD_CYC = 5'h01;
  localparam logic [4:0] RECOV_CYC = 5'h01;
  localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000000 / CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_RESET = 3'h1,
    OP_ERASE = 3'h2,
    OP_PROG = 3'h3,
    OP_READ_ID = 3'h4,
    OP_UNLOCK = 3'h5,
    OP_LOCK = 3'h6
  } fcs_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RESP = 4'b1000
  } fcs_st_e;

  typedef enum logic [4:0] {
    BC_IDLE = 5'b00001,
    BC_SETUP = 5'b00010,
    BC_STROBE = 5'b00100,
    BC_HOLD = 5'b01000,
    BC_RECOV = 5'b10000
  } fcs_bc_e;

endpackage

//--- verilog/fcs_bus_cycle.sv
`timescale 1ns/1ps
module fcs_bus_cycle (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  input wire logic start, // Begin one cycle
  input wire logic is_wr, // Write cycle
  input wire logic [fcs_pkg::ADDR_W-1:0] addr, // Cycle address
  input wire logic [7:0] wdata, // Write byte
  output logic done, // Cycle finished
  output logic [7:0] rdata, // Read byte
  output logic flash_ce_n, // Chip select
  output logic flash_oe_n, // Output gate
  output logic flash_we_n, // Write strobe
  output logic [fcs_pkg::ADDR_W-1:0] flash_addr, // Address pins
  output logic [7:0] flash_dq_o, // Data out
  output logic flash_dq_oe, // Data drive enable
  input wire logic [7:0] flash_dq_i // Data in
);
  import fcs_pkg::*;

  fcs_bc_e st_q;
  logic [4:0] cnt_q;
  logic wr_q;
  logic last;

  assign last = (cnt_q == 5'h01);
  assign done = (st_q == BC_RECOV) && last;

  // ****************************************
  // Cycle phases
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= BC_IDLE;
      cnt_q <= 5'h00;
    end else begin
      unique case (st_q)
        BC_IDLE: if (start) begin
          st_q <= BC_SETUP;
          cnt_q <= SETUP_CYC;
        end
        BC_SETUP: if (last) begin
          st_q <= BC_STROBE;
          cnt_q <= wr_q ? WE_PULSE_CYC : READ_ACC_CYC;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        BC_STROBE: if (last) begin
          st_q <= BC_HOLD;
          cnt_q <= HOLD_CYC;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        BC_HOLD: if (last) begin
          st_q <= BC_RECOV;
          cnt_q <= RECOV_CYC;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        BC_RECOV: if (last) begin
          st_q <= BC_IDLE;
        end else begin
          cnt_q <= cnt_q - 5'h01;
        end
        default: begin
          st_q <= BC_IDLE;
          cnt_q <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      flash_addr <= '0;
      flash_dq_o <= 8'h00;
    end else if (st_q == BC_IDLE && start) begin
      wr_q <= is_wr;
      flash_addr <= addr;
      flash_dq_o <= wdata;
    end
  end

  // ****************************************
  // Pins, one cycle behind the phase
  // ****************************************
  // Writes keep the gate high and select low around the strobe
  // Reads raise gate and select on the same edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
    end else begin
      flash_ce_n <= !(st_q == BC_SETUP || st_q == BC_STROBE ||
                      (st_q == BC_HOLD && wr_q));
      flash_oe_n <= !(st_q == BC_STROBE && !wr_q);
      flash_we_n <= !(st_q == BC_STROBE && wr_q);
      flash_dq_oe <= wr_q && (st_q == BC_SETUP || st_q == BC_STROBE ||
                              st_q == BC_HOLD);
    end
  end

  // Sample at the end of the gate-low window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (st_q == BC_HOLD && !wr_q) begin
      rdata <= flash_dq_i;
    end
  end

endmodule

//--- verilog/fcs_flash_host.sv
`timescale 1ns/1ps
module fcs_flash_host #(
  parameter int unsigned POLL_TIMEOUT_CYC = fcs_pkg::ERASE_MAX_CYC // Poll limit
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Idle, can accept
  input wire fcs_pkg::fcs_op_e cmd_op, // Operation
  input wire logic [fcs_pkg::ADDR_W-1:0] cmd_addr, // Target address
  input wire logic [7:0] cmd_wdata, // Program byte
  output logic rsp_valid, // Result pulse
  output logic [15:0] rsp_data, // Read or ID result
  output logic rsp_err, // Refused or timed out
  output logic software_write_lock, // Believed lock state
  output logic flash_ce_n, // Chip select
  output logic flash_oe_n, // Output gate
  output logic flash_we_n, // Write strobe
  output logic [fcs_pkg::ADDR_W-1:0] flash_addr, // Address pins
  output logic [7:0] flash_dq_o, // Data out
  output logic flash_dq_oe, // Data drive enable
  input wire logic [7:0] flash_dq_i // Data in
);
  import fcs_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic needs_unlock(input fcs_op_e op);
    return (op == OP_ERASE) || (op == OP_PROG);
  endfunction

  function automatic logic [ADDR_W-1:0] prot_addr(input fcs_op_e op,
                                                  input logic [2:0] idx);
    logic [15:0] a;
    a = (op == OP_LOCK) ? LOCK_SEQ[idx] : UNLOCK_SEQ[idx];
    return {3'b000, a};
  endfunction

  // Erase: toggle bit steady; program: byte equals what was written
  function automatic logic poll_ok(input logic is_erase,
                                   input logic [7:0] rd,
                                   input logic [7:0] prev,
                                   input logic have_prev,
                                   input logic [7:0] wd);
    logic ok;
    ok = 1'b0;
    if (is_erase) begin
      ok = have_prev && (rd[TOGGLE_STATUS_BIT] == prev[TOGGLE_STATUS_BIT]);
    end else begin
      ok = (rd[COMPLETION_POLL_BIT] == wd[COMPLETION_POLL_BIT]) &&
           (rd == wd);
    end
    return ok;
  endfunction

  // ****************************************
  // State
  // ****************************************
  fcs_st_e st_q;
  fcs_op_e op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  logic [2:0] step_q;
  logic poll_q;
  logic lock_q;
  logic [7:0] prev_q;
  logic have_prev_q;
  logic [1:0] conf_q;
  logic [TMO_W-1:0] tmo_q;
  logic [15:0] rsp_data_q;
  logic rsp_err_q;

  logic cmd_fire;
  logic refuse;
  logic bus_start;
  logic bus_wr;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0] bus_data;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic nx_last;
  logic poll_good;
  logic poll_end;
  logic tmo_exp;
  logic finish;

  assign cmd_ready = (st_q == ST_IDLE);
  assign cmd_fire = cmd_valid && cmd_ready;
  // Erase and program are never sent while locked
  assign refuse = needs_unlock(cmd_op) && lock_q;
  assign bus_start = (st_q == ST_ISSUE);
  assign rsp_valid = (st_q == ST_RESP);
  assign rsp_data = rsp_data_q;
  assign rsp_err = rsp_err_q;
  assign software_write_lock = lock_q;

  // ****************************************
  // Next bus cycle
  // ****************************************
  always_comb begin
    bus_wr = 1'b0;
    bus_addr = addr_q;
    bus_data = CMD_RESET;
    nx_last = 1'b0;
    if (poll_q) begin
      // Status reads at the target itself
      bus_wr = 1'b0;
    end else begin
      unique case (op_q)
        OP_READ: begin
          nx_last = 1'b1;
        end
        OP_RESET: begin
          bus_wr = 1'b1;
          bus_data = CMD_RESET;
          nx_last = 1'b1;
        end
        OP_ERASE: begin
          bus_wr = 1'b1;
          if (step_q == 3'h0) begin
            bus_data = CMD_ERASE_SETUP;
          end else begin
            bus_data = CMD_ERASE_EXEC;
            bus_addr = {addr_q[ADDR_W-1:SECTOR_LSB], 8'h00};
            nx_last = 1'b1;
          end
        end
        OP_PROG: begin
          bus_wr = 1'b1;
          if (step_q == 3'h0) begin
            bus_data = CMD_PROG_SETUP;
          end else begin
            bus_data = wdata_q;
            nx_last = 1'b1;
          end
        end
        OP_READ_ID: begin
          unique case (step_q)
            3'h0: begin
              bus_wr = 1'b1;
              bus_data = CMD_READ_ID;
            end
            3'h1: bus_addr = ID_MAKER_ADDR;
            3'h2: bus_addr = ID_PART_ADDR;
            default: begin
              // Leave ID mode with a valid command
              bus_wr = 1'b1;
              bus_data = CMD_RESET;
              nx_last = 1'b1;
            end
          endcase
        end
        OP_UNLOCK, OP_LOCK: begin
          bus_addr = prot_addr(op_q, step_q);
          nx_last = (step_q == SEQ_LAST);
        end
        default: begin
          nx_last = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Completion polling
  // ****************************************
  // One good read plus two confirming ones guards against a read
  // that races the internal completion
  assign poll_good = poll_ok(op_q == OP_ERASE, bus_rdata, prev_q,
                             have_prev_q, wdata_q);
  assign poll_end = poll_good && (conf_q == CONFIRM_READS);
  assign tmo_exp = (tmo_q >= TMO_W'(POLL_TIMEOUT_CYC));
  assign finish = bus_done &&
    (poll_q ? (poll_end || tmo_exp) : (nx_last && !needs_unlock(op_q)));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 8'h00;
      have_prev_q <= 1'b0;
      conf_q <= 2'h0;
    end else if (cmd_fire) begin
      have_prev_q <= 1'b0;
      conf_q <= 2'h0;
    end else if (st_q == ST_WAIT && bus_done && poll_q) begin
      prev_q <= bus_rdata;
      have_prev_q <= 1'b1;
      conf_q <= poll_good ? conf_q + 2'h1 : 2'h0;
    end
  end

  // Bounds the wait when the device never settles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmo_q <= '0;
    end else if (cmd_fire) begin
      tmo_q <= '0;
    end else if (poll_q && !tmo_exp) begin
      tmo_q <= tmo_q + TMO_W'(1);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (cmd_fire) begin
          st_q <= refuse ? ST_RESP : ST_ISSUE;
        end
        ST_ISSUE: st_q <= ST_WAIT;
        ST_WAIT: if (finish) begin
          st_q <= ST_RESP;
        end else if (bus_done) begin
          st_q <= ST_ISSUE;
        end
        ST_RESP: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_READ;
      addr_q <= '0;
      wdata_q <= 8'h00;
    end else if (cmd_fire) begin
      op_q <= cmd_op;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
    end
  end

  // Erase and program move on to polling after the execute write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 3'h0;
      poll_q <= 1'b0;
    end else if (cmd_fire) begin
      step_q <= 3'h0;
      poll_q <= 1'b0;
    end else if (st_q == ST_WAIT && bus_done) begin
      if (poll_q) begin
        poll_q <= !(poll_end || tmo_exp);
      end else if (nx_last) begin
        poll_q <= needs_unlock(op_q);
      end else begin
        step_q <= step_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Lock tracking
  // ****************************************
  // Reset command leaves this alone; only the read sequences move it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b1;
    end else if (st_q == ST_WAIT && finish && !poll_q) begin
      if (op_q == OP_UNLOCK) begin
        lock_q <= 1'b0;
      end else if (op_q == OP_LOCK) begin
        lock_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Result
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data_q <= 16'h0000;
      rsp_err_q <= 1'b0;
    end else if (cmd_fire) begin
      rsp_data_q <= 16'h0000;
      rsp_err_q <= refuse;
    end else if (st_q == ST_WAIT && bus_done) begin
      if (poll_q) begin
        rsp_data_q <= {8'h00, bus_rdata};
        rsp_err_q <= !poll_end;
      end else if (op_q == OP_READ) begin
        rsp_data_q <= {8'h00, bus_rdata};
      end else if (op_q == OP_READ_ID && step_q == 3'h1) begin
        rsp_data_q[15:8] <= bus_rdata;
      end else if (op_q == OP_READ_ID && step_q == 3'h2) begin
        rsp_data_q[7:0] <= bus_rdata;
      end
    end
  end

  // ****************************************
  // Pin cycle engine
  // ****************************************
  fcs_bus_cycle u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(bus_start),
    .is_wr(bus_wr),
    .addr(bus_addr),
    .wdata(bus_data),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

endmodule

//--- sim/fcs_monitor.sv
`timescale 1ns/1ps
module fcs_monitor #(
  parameter int unsigned POLL_TIMEOUT_CYC = 200 // Poll limit
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic cmd_valid, // Offer
  input wire logic cmd_ready, // Idle
  input wire fcs_pkg::fcs_op_e cmd_op, // Op
  input wire logic [fcs_pkg::ADDR_W-1:0] cmd_addr, // Addr
  input wire logic [7:0] cmd_wdata, // Byte
  input wire logic rsp_valid, // Result
  input wire logic [15:0] rsp_data, // Data
  input wire logic rsp_err, // Error
  input wire logic software_write_lock, // Lock
  input wire logic flash_ce_n, // Select
  input wire logic flash_oe_n, // Gate
  input wire logic flash_we_n, // Strobe
  input wire logic [fcs_pkg::ADDR_W-1:0] flash_addr, // Pins
  input wire logic [7:0] flash_dq_o, // Out
  input wire logic flash_dq_oe, // Drive
  input wire logic [7:0] flash_dq_i // In
);
  import fcs_pkg::*;
  logic [4:0] oe_cnt_q;
  logic [7:0] last_wr_q;
  fcs_op_e op_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) oe_cnt_q <= 5'h00;
    else if (!flash_oe_n) oe_cnt_q <= oe_cnt_q + 5'h01;
    else oe_cnt_q <= 5'h00;
  end
  // Byte seen by the device on the previous strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) last_wr_q <= 8'h00;
    else if (!flash_we_n) last_wr_q <= flash_dq_o;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) op_q <= OP_READ;
    else if (cmd_valid && cmd_ready) op_q <= cmd_op;
  end
  property p_we_framed;
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe;
  endproperty
  a_we_framed: assert property (p_we_framed)
    else $error("strobe low outside a write frame");
  property p_we_pulse;
    $fell(flash_we_n) |=>
      ($rose(flash_we_n) && !flash_ce_n && flash_dq_oe) ##1 flash_ce_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("strobe pulse or hold wrong");
  property p_wr_stable;
    !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o);
  endproperty
  a_wr_stable: assert property (p_wr_stable)
    else $error("address or data moved under strobe");
  property p_exec_order;
    $fell(flash_we_n) && flash_dq_o == CMD_ERASE_EXEC &&
      last_wr_q != CMD_PROG_SETUP |->
      last_wr_q == CMD_ERASE_SETUP && flash_addr[7:0] == 8'h00;
  endproperty
  a_exec_order: assert property (p_exec_order)
    else $error("erase execute without setup");
  property p_rd_gate;
    !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe;
  endproperty
  a_rd_gate: assert property (p_rd_gate)
    else $error("gate low outside a read");
  property p_rd_len;
    $rose(flash_oe_n) |-> oe_cnt_q == READ_ACC_CYC && flash_ce_n;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read gate length wrong");
  property p_refuse;
    cmd_valid && cmd_ready && software_write_lock &&
      (cmd_op == OP_ERASE || cmd_op == OP_PROG) |=>
      (rsp_valid && rsp_err && flash_ce_n) ##1 flash_ce_n;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("locked write not refused");
  property p_unlock;
    rsp_valid && op_q == OP_UNLOCK |=> !software_write_lock;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("lock flag kept after unlock");
  property p_lock;
    rsp_valid && op_q == OP_LOCK |=> software_write_lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag clear after lock");
  c_refuse: cover property (rsp_valid && rsp_err);
  c_unlock: cover property (rsp_valid && op_q == OP_UNLOCK);
  c_erase: cover property ($fell(flash_we_n) && flash_dq_o == CMD_ERASE_EXEC);
endmodule

//--- sim/fcs_flash_model.sv
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
  parameter int ERASE_NS = 1000, // Sector erase time
  parameter int PROG_NS = 600 // Byte program time
) (
  input wire logic ce_n, // Select
  input wire logic oe_n, // Gate
  input wire logic we_n, // Strobe
  input wire logic [18:0] addr, // Address
  input wire logic [7:0] din, // Bus level
  input wire logic slow, // Stretch busy time
  output logic [7:0] dout // Driven level
);
  import fcs_pkg::*;
  logic [7:0] mem [int];
  logic lock = 1'b1;
  logic busy = 1'b0;
  logic tgl = 1'b0;
  logic is_prog = 1'b0;
  logic wr_act = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic [18:0] wa = '0;
  int mode = 0;
  int ui = 0;
  int li = 0;
  int dly = 0;
  realtime tf = 0;
  wire rd = !ce_n && !oe_n;
  function automatic logic [7:0] rdm(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  task automatic go(input int t, input logic p, input logic [7:0] d);
    dly = t;
    is_prog = p;
    pdata = d;
    busy = 1'b1;
    mode = 0;
  endtask
  // ****
  // Command decode
  // ****
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n && oe_n) begin
      wa = addr;
      tf = $realtime;
      wr_act = 1'b1;
    end
  always @(posedge we_n or posedge ce_n) begin
    if (wr_act && !busy && $realtime - tf >= WE_PULSE_MIN_NS) begin
      if (mode == 1 && din == CMD_ERASE_EXEC) begin
        for (int i = 0; i < 256; i++) mem[int'({wa[18:8], 8'(i)})] = 8'hFF;
        go(ERASE_NS, 1'b0, 8'hFF);
      end else if (mode == 2) begin
        mem[int'(wa)] = rdm(wa) & din;
        go(PROG_NS, 1'b1, din);
      end else if (mode == 1) mode = 0;
      else if (din == CMD_ERASE_SETUP && !lock) mode = 1;
      else if (din == CMD_PROG_SETUP && !lock) mode = 2;
      else if (din == CMD_READ_ID) mode = 3;
      else if (din == CMD_RESET) mode = 0;
    end
    wr_act = 1'b0;
  end
  always begin
    wait (busy);
    #(slow ? 20 * dly : dly);
    busy = 1'b0;
  end
  // ****
  // Read path and lock sequences
  // ****
  always @* begin
    if (busy) val = {is_prog & ~pdata[7], tgl, pdata[5:0]};
    else if (mode == 3 && addr < 2) val = addr[0] ? PART_CODE : MAKER_CODE;
    else val = rdm(addr);
    dout = rd ? val : ~last;
  end
  always @(negedge rd) begin
    last = val;
    if (busy) tgl = ~tgl;
    ui = (addr == 19'(UNLOCK_SEQ[ui])) ? ui + 1 : 0;
    li = (addr == 19'(LOCK_SEQ[li])) ? li + 1 : 0;
    if (ui == SEQ_LEN) lock = 1'b0;
    if (li == SEQ_LEN) lock = 1'b1;
    if (ui == SEQ_LEN) ui = 0;
    if (li == SEQ_LEN) li = 0;
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value
  localparam logic [7:0] PT = 8'hC3; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic slow = 1'b0;
  fcs_op_e cmd_op = OP_READ;
  logic [18:0] cmd_addr = 19'h00000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_err, software_write_lock;
  logic [15:0] rsp_data;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [18:0] flash_addr;
  logic [7:0] flash_dq_o, dev_dq, dq_w;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 84671;
  int ref_lock = 1;
  int ref_mem [int];
  int progq [$];
  assign dq_w = flash_dq_oe ? flash_dq_o : dev_dq;
  always #10 clk_sys = ~clk_sys;
  fcs_flash_host #(.POLL_TIMEOUT_CYC(300)) dut_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .software_write_lock(software_write_lock), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_dq_i(dq_w));
  fcs_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) dev_u (.ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr), .din(dq_w),
    .slow(slow), .dout(dev_dq));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic int ref_rd(input int a);
    return ref_mem.exists(a) ? ref_mem[a] : 255;
  endfunction
  task automatic wipe(input int s);
    for (int i = 0; i < 256; i++) ref_mem[s * 256 + i] = 255;
  endtask
  // Offer one command, wait for its result, compare
  task automatic op(input fcs_op_e c, input int a, input int d,
    input logic [15:0] ed, input logic ee, input logic cd);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = c;
    cmd_addr = 19'(a);
    cmd_wdata = 8'(d);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(rsp_valid), 16'h0001, "response");
    if (cd) check(rsp_data, ed, "data");
    check(16'(rsp_err), 16'(ee), "error flag");
    @(negedge clk_sys);
    check(16'(software_write_lock), 16'(ref_lock), "lock flag");
  endtask
  initial begin
    #(20 * 60000);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    int s;
    int o;
    int d;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    check(16'(software_write_lock), 16'h0001, "rst lock");
    check(16'({cmd_ready, flash_ce_n}), 16'h0003, "rst idle");
    op(OP_READ_ID, 0, 0, {MK, PT}, 1'b0, 1'b1);
    op(OP_ERASE, 'h100, 0, 16'h0000, 1'b1, 1'b1);
    ref_lock = 0;
    op(OP_UNLOCK, 0, 0, 16'h0000, 1'b0, 1'b1);
    repeat (4) begin
      s = $unsigned($random(seed)) % 2048;
      op(OP_ERASE, s * 256 + 'h5A, 0, 16'h00FF, 1'b0, 1'b1);
      wipe(s);
      for (int k = 0; k < 3; k++) begin
        o = s * 256 + ($unsigned($random(seed)) % 64) * 4 + k;
        d = $unsigned($random(seed)) % 256;
        op(OP_PROG, o, d, 16'(d), 1'b0, 1'b1);
        ref_mem[o] = d;
        progq.push_back(o);
        op(OP_READ, o, 0, 16'(ref_rd(o)), 1'b0, 1'b1);
      end
      op(OP_READ, s * 256 + 'hFF, 0, 16'h00FF, 1'b0, 1'b1);
      op(OP_ERASE, o, 0, 16'h00FF, 1'b0, 1'b1);
      wipe(s);
    end
    foreach (progq[i]) begin
      o = progq[i];
      op(OP_READ, o, 0, 16'(ref_rd(o)), 1'b0, 1'b1);
    end
    op(OP_RESET, 0, 0, 16'h0000, 1'b0, 1'b1);
    op(fcs_op_e'(3'h7), o, 0, 16'h0000, 1'b0, 1'b1);
    slow = 1'b1;
    op(OP_PROG, o, 'hA5, 16'h0000, 1'b1, 1'b0);
    slow = 1'b0;
    ref_mem[o] = 'hA5;
    repeat (500) @(negedge clk_sys);
    op(OP_READ, o, 0, 16'(ref_rd(o)), 1'b0, 1'b1);
    ref_lock = 1;
    op(OP_LOCK, 0, 0, 16'h0000, 1'b0, 1'b1);
    op(OP_PROG, o, 0, 16'h0000, 1'b1, 1'b1);
    end_of_test();
  end
endmodule
bind fcs_flash_host fcs_monitor #(.POLL_TIMEOUT_CYC(POLL_TIMEOUT_CYC)) mon_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
  .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_err(rsp_err), .software_write_lock(software_write_lock),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));
